// file: pkg/vvm_pkg.sv
// package: register offsets, field positions, reset values and carriers for the monitor/fault status bank
package vvm_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_MONITOR_CHANGE_LATCH = 8'h0F;
  localparam logic [7:0] OFS_MONITOR_LIVE_STATUS = 8'h10;
  localparam logic [7:0] OFS_PORT_OPERATION_STATUS = 8'h11;
  localparam logic [7:0] OFS_FAULT_CHANGE_LATCH = 8'h12;

  // ==========================================================================
  // field positions
  localparam int BIT_BUS_IN_RANGE = 3;
  localparam int BIT_BUS_NEAR_ZERO = 2;
  localparam int BIT_BUS_PRESENT = 1;
  localparam int BIT_CABLE_SUPPLY_PRESENT = 0;
  localparam int BIT_ORIENTATION_SIDE = 7;
  localparam int BIT_THERMAL = 7;
  localparam int BIT_PULLUP_OVERVOLT = 5;
  localparam int BIT_PULLUP_GOOD = 4;
  localparam int BIT_SWITCH_REVERSE = 2;
  localparam int BIT_SWITCH_OVERCURRENT = 1;
  localparam int BIT_SWITCH_OVERVOLT = 0;
  localparam int ALERT_BIT_MONITOR = 5;
  localparam int ALERT_BIT_FAULT = 4;

  // ==========================================================================
  // reset values and the mask of used alert summary bits
  localparam logic [3:0] RST_MONITOR_LIVE = 4'h4;
  localparam logic [4:0] RST_FSM_STATE = 5'h08;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_ALERT = 8'h20;
  localparam logic [7:0] ALERT_USED_MASK = 8'h70;

  // ==========================================================================
  // attach state codes
  localparam logic [4:0] ST_UNATTACHED = 5'h08;
  localparam logic [4:0] ST_ATTACH_WAIT = 5'h09;
  localparam logic [4:0] ST_ATTACHED = 5'h0A;
  localparam logic [4:0] ST_ACC_UNATTACHED = 5'h0D;
  localparam logic [4:0] ST_ACC_WAIT = 5'h0E;
  localparam logic [4:0] ST_AUDIO_ACC = 5'h0F;
  localparam logic [4:0] ST_DEBUG_UNORIENTED = 5'h10;
  localparam logic [4:0] ST_ERROR_RECOVERY = 5'h13;
  localparam logic [4:0] ST_VCONN_DISCHARGE = 5'h18;
  localparam logic [4:0] ST_DEBUG_ORIENTED = 5'h19;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic bus_in_range;
    logic bus_near_zero;
    logic bus_present;
    logic cable_supply_present;
  } vvm_monitor_s;

  typedef struct packed {
    logic pullup_overvolt;
    logic pullup_good;
    logic [1:0] switch_reverse;
    logic [1:0] switch_overcurrent;
    logic [1:0] switch_overvolt;
  } vvm_fault_s;

  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } vvm_read_s;

endpackage

// file: hw/vvm_sync.sv
// two-flop synchroniser, width parameterised
`timescale 1ns/100ps
module vvm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // ==========================================================================
  // first stage is read only by the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: hw/vvm_change_latch.sv
// read-to-clear change latch: sets on any asserted event bit, set wins over clear
`timescale 1ns/100ps
module vvm_change_latch #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // events
  input wire logic [W-1:0] event_in,
  input wire logic clear,
  output logic [W-1:0] latch
);
  logic [W-1:0] next_latch;

  // ==========================================================================
  // a new event in the clearing cycle survives the clear
  assign next_latch = clear ? event_in : (latch | event_in); // [RULE18]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      latch <= '0;
    end else begin
      latch <= next_latch;
    end
  end
endmodule

// file: hw/vvm_status_bank.sv
// monitor and fault status register bank with change latches and alert summary
//
// Contract
// RULE1: bus in-range toggle sets monitor latch bit 3
// RULE2: bus near-zero toggle sets latch bit 2
// RULE3: bus presence toggle sets latch bit 1
// RULE4: cable supply toggle sets bit 0; 7:4 zero
// RULE5: live bit 3 follows in-range comparator
// RULE6: live bit 2 near-zero, resets to one
// RULE7: live bit 1 follows fixed undervoltage comparator
// RULE8: live bit 0 follows selected cable-supply comparator
// RULE9: cable supply bit zero unless supplied, enabled
// RULE10: attach requires bus near zero first
// RULE11: orientation bit 7 equals orientation pin
// RULE12: state code in bits 4:0, reset 08h
// RULE13: operation status never raises an alert
// RULE14: over-temperature sets fault latch bit 7
// RULE15: pull-up and switch fault changes set bits
// RULE16: nonzero latch sets its summary alert bit
// RULE17: alert low when unmasked summary bit set
// RULE18: event during clearing read is kept
`timescale 1ns/100ps
module vvm_status_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // analog comparator results (asynchronous)
  input wire logic cmp_bus_in_range,
  input wire logic cmp_bus_near_zero,
  input wire logic cmp_bus_present,
  input wire logic cmp_cable_high_thr,
  input wire logic cmp_cable_low_thr,
  input wire logic cmp_over_temp,
  input wire vvm_pkg::vvm_fault_s fault_in,
  // cable-supply monitor settings
  input wire logic cable_monitor_enable,
  input wire logic cable_low_threshold_sel,
  // attach detection (asynchronous)
  input wire logic sink_seen,
  input wire logic sink_on_second_pin,
  input wire logic accessory_seen,
  input wire logic audio_accessory,
  input wire logic debug_accessory,
  input wire logic error_seen,
  // alert summary mask, 1 masks
  input wire logic [7:0] alert_mask,
  // register read port
  input wire vvm_pkg::vvm_read_s rd_req,
  output logic [7:0] rd_data,
  // pins
  output logic orientation_side,
  output logic alert_n,
  output logic [7:0] alert_summary
);

  // ==========================================================================
  // synchronisers
  localparam int NS = 16;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {cmp_bus_in_range, cmp_bus_near_zero, cmp_bus_present, cmp_cable_high_thr,
                   cmp_cable_low_thr, cmp_over_temp, sink_seen, sink_on_second_pin,
                   accessory_seen, audio_accessory, debug_accessory, error_seen, fault_in[7:4]};
  logic [3:0] fault_lo_syn;

  vvm_sync #(.W(NS), .INIT(16'h4000)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(raw_in),
    .q(syn)
  );

  vvm_sync #(.W(4), .INIT(4'h0)) u_sync_lo (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(fault_in[3:0]),
    .q(fault_lo_syn)
  );

  wire s_in_range = syn[15];
  wire s_near_zero = syn[14];
  wire s_present = syn[13];
  wire s_cab_high = syn[12];
  wire s_cab_low = syn[11];
  wire s_over_temp = syn[10];
  wire s_sink = syn[9];
  wire s_second = syn[8];
  wire s_acc = syn[7];
  wire s_audio = syn[6];
  wire s_debug = syn[5];
  wire s_error = syn[4];
  vvm_pkg::vvm_fault_s s_fault;
  assign s_fault = {syn[3:0], fault_lo_syn};

  // ==========================================================================
  // live monitoring status
  vvm_pkg::vvm_monitor_s live;
  vvm_pkg::vvm_monitor_s next_live;
  wire cable_cmp = cable_low_threshold_sel ? s_cab_low : s_cab_high; // [RULE8]
  assign next_live.bus_in_range = s_in_range; // [RULE5]
  assign next_live.bus_near_zero = s_near_zero; // [RULE6]
  assign next_live.bus_present = s_present; // [RULE7]
  // a disabled detector forces absence
  assign next_live.cable_supply_present = cable_monitor_enable & cable_cmp; // [RULE9]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      live <= vvm_pkg::RST_MONITOR_LIVE; // [RULE6]
    end else begin
      live <= next_live;
    end
  end

  // ==========================================================================
  // attach state machine; codes are what software sees
  typedef enum {S_UNATT, S_WAIT, S_ATT, S_ACC_UN, S_ACC_WAIT, S_AUDIO, S_DBG_UN,
                S_ERR, S_DISCH, S_DBG_OR} vvm_state_e;
  vvm_state_e state;
  vvm_state_e next_state;
  logic orient;

  function automatic logic [4:0] state_code(input vvm_state_e s);
    unique case (s)
      S_UNATT: state_code = vvm_pkg::ST_UNATTACHED;
      S_WAIT: state_code = vvm_pkg::ST_ATTACH_WAIT;
      S_ATT: state_code = vvm_pkg::ST_ATTACHED;
      S_ACC_UN: state_code = vvm_pkg::ST_ACC_UNATTACHED;
      S_ACC_WAIT: state_code = vvm_pkg::ST_ACC_WAIT;
      S_AUDIO: state_code = vvm_pkg::ST_AUDIO_ACC;
      S_DBG_UN: state_code = vvm_pkg::ST_DEBUG_UNORIENTED;
      S_ERR: state_code = vvm_pkg::ST_ERROR_RECOVERY;
      S_DISCH: state_code = vvm_pkg::ST_VCONN_DISCHARGE;
      S_DBG_OR: state_code = vvm_pkg::ST_DEBUG_ORIENTED;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    if (s_error) begin
      next_state = S_ERR;
    end else begin
      unique case (state)
        S_UNATT: begin
          if (s_sink) next_state = S_WAIT;
          else if (s_acc) next_state = S_ACC_UN;
        end
        S_WAIT: begin
          if (!s_sink) next_state = S_UNATT;
          else if (live.bus_near_zero) next_state = S_ATT; // [RULE10]
        end
        S_ATT: if (!s_sink) next_state = S_DISCH;
        S_ACC_UN: begin
          if (!s_acc) next_state = S_UNATT;
          else next_state = S_ACC_WAIT;
        end
        S_ACC_WAIT: begin
          if (!s_acc) next_state = S_UNATT;
          else if (s_audio) next_state = S_AUDIO;
          else if (s_debug && live.bus_near_zero) next_state = S_DBG_UN; // [RULE10]
        end
        S_AUDIO: if (!s_acc) next_state = S_UNATT;
        S_DBG_UN: begin
          if (!s_acc) next_state = S_UNATT;
          else if (s_sink) next_state = S_DBG_OR;
        end
        S_DBG_OR: if (!s_acc) next_state = S_UNATT;
        S_ERR: next_state = S_UNATT;
        S_DISCH: next_state = S_UNATT;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= S_UNATT;
      orient <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == S_ATT && state != S_ATT) orient <= s_second;
    end
  end

  wire [4:0] fsm_code = state_code(state); // [RULE12]
  wire [7:0] op_status = {orient, 2'b00, fsm_code}; // [RULE11]
  assign orientation_side = orient; // [RULE11]

  // ==========================================================================
  // change detection
  vvm_pkg::vvm_fault_s fault_q;
  logic over_temp_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_q <= '0;
      over_temp_q <= 1'b0;
    end else begin
      fault_q <= s_fault;
      over_temp_q <= s_over_temp;
    end
  end

  // live register toggles; live itself is the previous sample
  wire [3:0] mon_evt = next_live ^ live; // [RULE1] [RULE2] [RULE3] [RULE4]
  wire [7:0] fault_diff = s_fault ^ fault_q;
  logic [7:0] flt_evt;
  assign flt_evt[vvm_pkg::BIT_THERMAL] = s_over_temp & ~over_temp_q; // [RULE14]
  assign flt_evt[6] = 1'b0;
  assign flt_evt[vvm_pkg::BIT_PULLUP_OVERVOLT] = fault_diff[7]; // [RULE15]
  assign flt_evt[vvm_pkg::BIT_PULLUP_GOOD] = fault_diff[6]; // [RULE15]
  assign flt_evt[3] = 1'b0;
  assign flt_evt[vvm_pkg::BIT_SWITCH_REVERSE] = |fault_diff[5:4]; // [RULE15]
  assign flt_evt[vvm_pkg::BIT_SWITCH_OVERCURRENT] = |fault_diff[3:2]; // [RULE15]
  assign flt_evt[vvm_pkg::BIT_SWITCH_OVERVOLT] = |fault_diff[1:0]; // [RULE15]

  // ==========================================================================
  // read decode and latches
  wire rd_mon_latch = rd_req.rd && rd_req.addr == vvm_pkg::OFS_MONITOR_CHANGE_LATCH;
  wire rd_flt_latch = rd_req.rd && rd_req.addr == vvm_pkg::OFS_FAULT_CHANGE_LATCH;
  logic [3:0] mon_latch;
  logic [7:0] flt_latch;

  vvm_change_latch #(.W(4)) u_mon_latch (
    .mclk(mclk),
    .rst_n(rst_n),
    .event_in(mon_evt),
    .clear(rd_mon_latch), // [RULE1] [RULE18]
    .latch(mon_latch)
  );

  vvm_change_latch #(.W(8)) u_flt_latch (
    .mclk(mclk),
    .rst_n(rst_n),
    .event_in(flt_evt),
    .clear(rd_flt_latch), // [RULE14] [RULE15]
    .latch(flt_latch)
  );

  logic [7:0] next_rd_data;
  always_comb begin
    unique case (rd_req.addr)
      vvm_pkg::OFS_MONITOR_CHANGE_LATCH: next_rd_data = {4'h0, mon_latch}; // [RULE4]
      vvm_pkg::OFS_MONITOR_LIVE_STATUS: next_rd_data = {4'h0, live};
      vvm_pkg::OFS_PORT_OPERATION_STATUS: next_rd_data = op_status;
      vvm_pkg::OFS_FAULT_CHANGE_LATCH: next_rd_data = flt_latch;
      default: next_rd_data = 8'h00;
    endcase
  end

  // ==========================================================================
  // alert summary; operation status has no path here
  logic [7:0] next_alert;
  always_comb begin
    next_alert = alert_summary;
    if (|mon_latch) next_alert[vvm_pkg::ALERT_BIT_MONITOR] = 1'b1; // [RULE16]
    if (|flt_latch) next_alert[vvm_pkg::ALERT_BIT_FAULT] = 1'b1; // [RULE16] [RULE13]
    if (!(|mon_latch) && rd_mon_latch) next_alert[vvm_pkg::ALERT_BIT_MONITOR] = 1'b0;
    if (!(|flt_latch) && rd_flt_latch) next_alert[vvm_pkg::ALERT_BIT_FAULT] = 1'b0;
    next_alert = next_alert & vvm_pkg::ALERT_USED_MASK;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      alert_summary <= vvm_pkg::RST_ALERT;
      alert_n <= 1'b1;
    end else begin
      rd_data <= next_rd_data;
      alert_summary <= next_alert;
      alert_n <= ~|(next_alert & ~alert_mask); // [RULE17]
    end
  end

  // ==========================================================================
  // assertions
  sequence live_toggles;
    live != $past(live);
  endsequence

  // the latch sets on the same edge that live changes, so a clearing read one cycle later must not fail this
  mon_latch_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    live_toggles |-> |mon_latch) else $error("monitor toggle not latched");
  near_zero_lat_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    mon_evt[2] |=> mon_latch[2]) else $error("near-zero change lost");
  present_lat_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
    mon_evt[1] |=> mon_latch[1]) else $error("presence change lost");
  mon_upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    $past(rd_mon_latch) |-> rd_data[7:4] == 4'h0) else $error("latch upper bits not zero");
  live_follow_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
    live.bus_in_range == $past(s_in_range)) else $error("in-range bit stale");
  cable_dis_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
    !cable_monitor_enable |=> !live.cable_supply_present) else $error("disabled supply shown present");
  attach_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
    (state == S_WAIT && !live.bus_near_zero && !s_error) |=> state != S_ATT) else $error("attach without near zero");
  orient_pin_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    $past(rd_req.rd && rd_req.addr == vvm_pkg::OFS_PORT_OPERATION_STATUS) |-> rd_data[7] == $past(orientation_side))
    else $error("orientation bit differs from pin");
  thermal_lat_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
    $rose(s_over_temp) |=> flt_latch[vvm_pkg::BIT_THERMAL]) else $error("over-temperature not latched");
  // a read leaves exactly the events of its own cycle behind
  keep_event_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE18]
    rd_mon_latch |=> mon_latch == $past(mon_evt)) else $error("event lost during clear");
  flt_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
    rd_flt_latch |=> flt_latch == $past(flt_evt)) else $error("fault latch clear wrong");
  // both states last a single cycle, so a host that reads every second cycle can miss them
  acc_code_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
    (state == S_UNATT && !s_error && !s_sink && s_acc) |=> fsm_code == vvm_pkg::ST_ACC_UNATTACHED)
    else $error("accessory state code wrong");
  disch_code_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
    (state == S_ATT && !s_error && !s_sink) |=> fsm_code == vvm_pkg::ST_VCONN_DISCHARGE)
    else $error("discharge state code wrong");
  alert_pin_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
    alert_n == ~|(alert_summary & ~$past(alert_mask))) else $error("alert pin mismatch");

endmodule

// file: testbench/vvm_host_model.sv
// host-side model that issues single-cycle register reads on the bank's read port
`timescale 1ns/100ps
module vvm_host_model (
  // clock
  input wire logic mclk,
  // read port
  output vvm_pkg::vvm_read_s rd_req,
  input wire logic [7:0] rd_data
);
  initial begin
    rd_req = '0;
  end

  // ==========================================================================
  // read access
  // launched after a falling edge and taken at the next rising edge; data is picked up
  // at the following falling edge, because a later sample could already show the cleared latch
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge mclk);
    rd_req.addr = addr;
    rd_req.rd = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    data = rd_data;
    rd_req.rd = 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the monitor and fault status bank
`timescale 1ns/100ps
`define CHK(name, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module tb;
  logic mclk, rst_n;
  logic cmp_bus_in_range, cmp_bus_near_zero, cmp_bus_present;
  logic cmp_cable_high_thr, cmp_cable_low_thr, cmp_over_temp;
  vvm_pkg::vvm_fault_s fault_in;
  logic cable_monitor_enable, cable_low_threshold_sel;
  logic sink_seen, sink_on_second_pin, accessory_seen, audio_accessory, debug_accessory, error_seen;
  logic [7:0] alert_mask;
  vvm_pkg::vvm_read_s rd_req;
  logic [7:0] rd_data;
  logic orientation_side, alert_n;
  logic [7:0] alert_summary;
  int error_cnt, checks;
  logic [3:0] live;
  logic [7:0] d, r;
  logic [7:0] raddr [5] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13};
  logic [7:0] rexp [5] = '{8'h00, 8'h04, 8'h08, 8'h00, 8'h00};
  logic [7:0] fmap [8] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h04, 8'h04, 8'h10, 8'h20};

  vvm_status_bank DUT (.mclk(mclk), .rst_n(rst_n), .cmp_bus_in_range(cmp_bus_in_range),
    .cmp_bus_near_zero(cmp_bus_near_zero), .cmp_bus_present(cmp_bus_present),
    .cmp_cable_high_thr(cmp_cable_high_thr), .cmp_cable_low_thr(cmp_cable_low_thr),
    .cmp_over_temp(cmp_over_temp), .fault_in(fault_in), .cable_monitor_enable(cable_monitor_enable),
    .cable_low_threshold_sel(cable_low_threshold_sel), .sink_seen(sink_seen),
    .sink_on_second_pin(sink_on_second_pin), .accessory_seen(accessory_seen),
    .audio_accessory(audio_accessory), .debug_accessory(debug_accessory), .error_seen(error_seen),
    .alert_mask(alert_mask), .rd_req(rd_req), .rd_data(rd_data), .orientation_side(orientation_side),
    .alert_n(alert_n), .alert_summary(alert_summary));

  vvm_host_model host (.mclk(mclk), .rd_req(rd_req), .rd_data(rd_data));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================================
  // helpers
  task automatic stop_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // covers the synchroniser, live and latch stages with margin
  task automatic settle();
    repeat (8) @(negedge mclk);
  endtask

  task automatic mon_check(input logic [7:0] lat);
    logic [7:0] v;
    settle();
    host.read(vvm_pkg::OFS_MONITOR_LIVE_STATUS, v);
    `CHK("monitor_live_status", {4'h0, live}, v)
    `CHK("alert_n", 1'b0, alert_n)
    host.read(vvm_pkg::OFS_MONITOR_CHANGE_LATCH, v);
    `CHK("monitor_change_latch", lat, v)
    host.read(vvm_pkg::OFS_MONITOR_CHANGE_LATCH, v);
    `CHK("monitor_change_latch cleared", 8'h00, v)
    repeat (2) @(negedge mclk);
    `CHK("alert_summary", 8'h00, alert_summary)
  endtask

  task automatic fault_check(input logic [7:0] lat);
    logic [7:0] v;
    settle();
    `CHK("alert_summary fault", 8'h10, alert_summary)
    host.read(vvm_pkg::OFS_FAULT_CHANGE_LATCH, v);
    `CHK("fault_change_latch", lat, v)
    host.read(vvm_pkg::OFS_FAULT_CHANGE_LATCH, v);
    `CHK("fault_change_latch cleared", 8'h00, v)
  endtask

  task automatic poll(input logic [4:0] st);
    for (int k = 0; k < 60; k++) begin
      host.read(vvm_pkg::OFS_PORT_OPERATION_STATUS, d);
      if (d[4:0] === st) break;
    end
  endtask

  // ==========================================================================
  // tests
  initial begin
    {cmp_bus_in_range, cmp_bus_present, cmp_cable_high_thr, cmp_cable_low_thr, cmp_over_temp} = '0;
    cmp_bus_near_zero = 1'b1;
    fault_in = '0;
    cable_monitor_enable = 1'b1;
    cable_low_threshold_sel = 1'b0;
    {sink_seen, sink_on_second_pin, accessory_seen, audio_accessory, debug_accessory, error_seen} = '0;
    alert_mask = 8'hFF;
    rst_n = 1'b0;
    error_cnt = 0;
    checks = 0;
    live = 4'h4;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    `CHK("alert_summary reset", 8'h20, alert_summary)
    `CHK("alert_n masked", 1'b1, alert_n)
    `CHK("orientation_side reset", 1'b0, orientation_side)
    alert_mask = 8'hCF;
    repeat (2) @(negedge mclk);
    `CHK("alert_n unmasked", 1'b0, alert_n)
    for (int i = 0; i < 5; i++) begin
      host.read(raddr[i], d);
      `CHK("register reset value", rexp[i], d)
    end
    repeat (2) @(negedge mclk);
    `CHK("alert_n idle", 1'b1, alert_n)
    for (int b = 3; b >= 0; b--) begin
      case (b)
        3: cmp_bus_in_range = ~cmp_bus_in_range;
        2: cmp_bus_near_zero = ~cmp_bus_near_zero;
        1: cmp_bus_present = ~cmp_bus_present;
        default: cmp_cable_high_thr = ~cmp_cable_high_thr;
      endcase
      live[b] = ~live[b];
      mon_check(8'h01 << b);
    end
    cable_low_threshold_sel = 1'b1;
    live[0] = 1'b0;
    mon_check(8'h01);
    cmp_cable_low_thr = 1'b1;
    live[0] = 1'b1;
    mon_check(8'h01);
    cable_monitor_enable = 1'b0;
    live[0] = 1'b0;
    mon_check(8'h01);
    // toggles landing at every offset around a clearing read must never be lost
    for (int s = 0; s < 6; s++) begin
      cmp_bus_present = ~cmp_bus_present;
      repeat (s) @(negedge mclk);
      r = 8'h00;
      for (int k = 0; k < 3; k++) begin
        host.read(vvm_pkg::OFS_MONITOR_CHANGE_LATCH, d);
        r = r | d;
      end
      `CHK("change kept during read", 1'b1, r[1])
    end
    for (int i = 0; i < 8; i++) begin
      fault_in[i] = 1'b1;
      fault_check(fmap[i]);
      fault_in[i] = 1'b0;
      fault_check(fmap[i]);
    end
    cmp_over_temp = 1'b1;
    fault_check(8'h80);
    cmp_over_temp = 1'b0;
    settle();
    host.read(vvm_pkg::OFS_FAULT_CHANGE_LATCH, d);
    `CHK("thermal on falling level", 8'h00, d)
    sink_on_second_pin = 1'b1;
    sink_seen = 1'b1;
    repeat (30) @(negedge mclk);
    host.read(vvm_pkg::OFS_PORT_OPERATION_STATUS, d);
    `CHK("attach without near zero", 1'b0, d[4:0] === vvm_pkg::ST_ATTACHED)
    cmp_bus_near_zero = 1'b1;
    settle();
    host.read(vvm_pkg::OFS_MONITOR_CHANGE_LATCH, d);
    host.read(vvm_pkg::OFS_MONITOR_CHANGE_LATCH, d);
    poll(vvm_pkg::ST_ATTACHED);
    `CHK("attach_fsm_state attached", vvm_pkg::ST_ATTACHED, d[4:0])
    `CHK("orientation_side bit", 1'b1, d[7])
    `CHK("orientation_side pin", 1'b1, orientation_side)
    `CHK("alert_summary on state change", 8'h00, alert_summary)
    error_seen = 1'b1;
    poll(vvm_pkg::ST_ERROR_RECOVERY);
    `CHK("attach_fsm_state error", vvm_pkg::ST_ERROR_RECOVERY, d[4:0])
    error_seen = 1'b0;
    sink_seen = 1'b0;
    poll(vvm_pkg::ST_UNATTACHED);
    `CHK("attach_fsm_state unattached", vvm_pkg::ST_UNATTACHED, d[4:0])
    `CHK("alert_n after state changes", 1'b1, alert_n)
    // detach without error passes through the discharge wait state
    sink_seen = 1'b1;
    poll(vvm_pkg::ST_ATTACHED);
    `CHK("attach_fsm_state reattached", vvm_pkg::ST_ATTACHED, d[4:0])
    sink_seen = 1'b0;
    poll(vvm_pkg::ST_UNATTACHED);
    `CHK("attach_fsm_state detached", vvm_pkg::ST_UNATTACHED, d[4:0])
    accessory_seen = 1'b1;
    poll(vvm_pkg::ST_ACC_WAIT);
    `CHK("attach_fsm_state accessory wait", vvm_pkg::ST_ACC_WAIT, d[4:0])
    audio_accessory = 1'b1;
    poll(vvm_pkg::ST_AUDIO_ACC);
    `CHK("attach_fsm_state audio", vvm_pkg::ST_AUDIO_ACC, d[4:0])
    {accessory_seen, audio_accessory} = 2'h0;
    poll(vvm_pkg::ST_UNATTACHED);
    `CHK("attach_fsm_state accessory gone", vvm_pkg::ST_UNATTACHED, d[4:0])
    {accessory_seen, debug_accessory} = 2'h3;
    poll(vvm_pkg::ST_DEBUG_UNORIENTED);
    `CHK("attach_fsm_state debug", vvm_pkg::ST_DEBUG_UNORIENTED, d[4:0])
    sink_seen = 1'b1;
    poll(vvm_pkg::ST_DEBUG_ORIENTED);
    `CHK("attach_fsm_state debug oriented", vvm_pkg::ST_DEBUG_ORIENTED, d[4:0])
    `CHK("alert_summary after accessory", 8'h00, alert_summary)
    stop_test();
  end

  // the whole sequence needs a few hundred cycles
  initial begin
    #(25 * 20000);
    error_cnt++;
    stop_test();
  end
endmodule
